/* inc/tc_pkg.sv */
// Constants, types and register map of the up/down timer/counter block.
// Assumes a single clock domain (CLK) and an APB master with 32-bit data.
//
// Overview of operation
// - Sixteen-bit up/down counter with compare and PWM.
// - Watchdog, clear-on-match, fast PWM, dual-slope PWM.
// - Counting clock source chosen by configuration.
// - Programmable prescaler divides the selected clock.
// - Overflow, compare and capture interrupt causes.
// - One level interrupt output to user logic.
// - Wake-up pulse to the standby controller.
// - Capture input rising edge stamps the count.
// - Capture only in non-PWM modes with bus.
// - Stand-alone: interrupt output shows counter overflow.
// - With bus: interrupt gated by status, mask, enable.
// - External reset pin enable preset always on.
// - Glitch-free PWM with variable period on output.
// - Stand-alone runs from preloaded registers, pin reset.
// - Registers reachable by bus master over the bus.
package tc_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_TOP     = 8'h04;
	localparam logic [7:0] OFS_CMP     = 8'h08;
	localparam logic [7:0] OFS_COUNT   = 8'h0C;
	localparam logic [7:0] OFS_CAPTURE = 8'h10;
	localparam logic [7:0] OFS_STATUS  = 8'h14;
	localparam logic [7:0] OFS_MASK    = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h1C;

	// ==========================================================
	// Control register fields
	localparam int CTRL_RUN     = 0;   // Counter runs
	localparam int CTRL_MODE_LO = 1;   // Two bits of mode
	localparam int CTRL_SRC     = 3;   // 0 system clock, 1 pin clock
	localparam int CTRL_PRE_LO  = 4;   // Three bits of prescale
	localparam int CTRL_CAP_EN  = 7;   // Capture enable
	localparam int CTRL_INV     = 8;   // Output polarity

	// ==========================================================
	// Status bit positions
	localparam int ST_OVF = 0;
	localparam int ST_CMP = 1;
	localparam int ST_CAP = 2;

	// ==========================================================
	// Reset and preload values
	localparam logic [8:0]  CTRL_RESET    = 9'h000;
	localparam logic [15:0] TOP_RESET     = 16'hFFFF;
	localparam logic [15:0] CMP_RESET     = 16'h8000;
	localparam logic [15:0] START_VALUE   = 16'h0000;
	localparam logic [2:0]  IRQ_RESET     = 3'h0;
	localparam logic [8:0]  CTRL_PRELOAD  = 9'h001;
	localparam logic        RST_PIN_ENA   = 1'b1;

	// ==========================================================
	// Operating modes
	typedef enum logic [1:0] {
		MODE_WDOG,
		MODE_CTC,
		MODE_FPWM,
		MODE_PFCPWM
	} mode_t;

	// Counting direction state
	typedef enum logic {
		DIR_UP,
		DIR_DOWN
	} dir_t;

	// ==========================================================
	// Complete state of the block
	typedef struct packed {
		logic [8:0]  ctrl;
		logic [15:0] top;
		logic [15:0] cmp;
		logic [15:0] top_buf;
		logic [15:0] cmp_buf;
		logic [15:0] count;
		logic [15:0] capture;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic [2:0]  irq_en;
		logic [7:0]  prescale;
		dir_t        dir;
		logic        tclk_sync1;
		logic        tclk_sync2;
		logic        tclk_prev;
		logic        cap_sync1;
		logic        cap_sync2;
		logic        cap_prev;
		logic        wave;
		logic        wake;
		logic [31:0] rdata;
	} state_t;

endpackage

/* rtl/tc_core.sv */
// Up/down timer/counter with compare output, PWM and input capture.
// Assumes CLK at 40 MHz, synchronous active-low RESETN, APB master.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps

module tc_core (
	// Clock, enable and reset
	input  wire logic        CLK,
	input  wire logic        CE,
	input  wire logic        RESETN,
	input  wire logic        TIMER_RESET_LOW,
	// Configuration strap and pin count clock
	input  wire logic        BUS_MODE,
	input  wire logic        TIMER_CLOCK_IN,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Timer pins
	input  wire logic        CAPTURE_TRIGGER_IN,
	output logic             COMPARE_WAVE_OUT,
	output logic             TIMER_IRQ_OUT,
	output logic             WAKE_OUT,
	output logic             TIMER_RESET_PIN_ENABLE,
	output logic      [15:0] RUNNING_COUNT
);
	import tc_pkg::*;

	// ==========================================================
	// Address decode, used only for the PSLVERR error response
	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == OFS_CTRL) || (a == OFS_TOP) ||
			(a == OFS_CMP) || (a == OFS_COUNT) ||
			(a == OFS_CAPTURE) || (a == OFS_STATUS) ||
			(a == OFS_MASK) || (a == OFS_IRQ_EN);
	endfunction

	// Prescaler terminal count for a 3-bit setting
	function automatic logic [7:0] pre_limit(input logic [2:0] s);
		pre_limit = 8'(( 9'h001 << s) - 9'h001);
	endfunction

	// ==========================================================
	// State registers
	state_t st;         // Present state
	state_t next_st;    // Next state

	// Decoded controls
	mode_t       mode;        // Active mode
	logic [2:0]  pre_sel;     // Prescale setting
	logic        src_pin;     // Count the pin clock
	logic        pwm_mode;    // Either PWM mode
	logic        acc;         // APB access phase
	logic        wr;          // APB write strobe
	logic        tick;        // Source edge seen
	logic        step;        // Counter advances now
	logic        at_top;      // Count at period end
	logic        at_zero;     // Count at bottom
	logic        match;       // Count equals compare
	logic        ovf_ev;      // Overflow event
	logic        cmp_ev;      // Compare event
	logic        cap_ev;      // Capture event
	logic [2:0]  events;      // All events
	logic        irq_bus;     // Gated bus interrupt
	logic        ovf_flag;    // Stand-alone overflow flag

	assign mode     = mode_t'(st.ctrl[CTRL_MODE_LO +: 2]);
	assign pre_sel  = st.ctrl[CTRL_PRE_LO +: 3];
	assign src_pin  = st.ctrl[CTRL_SRC];
	assign pwm_mode = (mode == MODE_FPWM) || (mode == MODE_PFCPWM);
	assign acc      = PSEL && PENABLE;
	assign wr       = acc && PWRITE && BUS_MODE;
	assign tick     = src_pin ? (st.tclk_sync2 && !st.tclk_prev) : 1'b1;
	// At or past the limit, so a smaller new setting takes hold at once
	assign step     = st.ctrl[CTRL_RUN] && tick &&
		(st.prescale >= pre_limit(pre_sel));
	assign at_top   = (st.count == st.top);
	assign at_zero  = (st.count == START_VALUE);
	assign match    = (st.count == st.cmp);

	// Overflow ends a period, none in clear-on-match mode; dual-slope PWM counts it at the bottom
	assign ovf_ev = step && ((mode == MODE_PFCPWM) ?
		(at_zero && st.dir == DIR_DOWN) :
		(mode == MODE_CTC) ? 1'b0 : at_top);
	assign cmp_ev = step && match;
	// Capture only outside PWM and with the bus present
	assign cap_ev = st.ctrl[CTRL_CAP_EN] && !pwm_mode && BUS_MODE &&
		st.cap_sync2 && !st.cap_prev;
	assign events = {cap_ev, cmp_ev, ovf_ev};

	// ==========================================================
	// Interrupt gating through status, mask and enable registers
	assign irq_bus  = |(st.status & st.mask & st.irq_en);
	assign ovf_flag = st.status[ST_OVF];

	// ==========================================================
	// Outputs from registers; PREADY and TIMER_RESET_PIN_ENABLE are constant, PSLVERR decoded from the bus
	assign PRDATA                 = st.rdata;
	assign PREADY                 = 1'b1;
	assign PSLVERR                = acc && !known_addr(PADDR);
	assign COMPARE_WAVE_OUT       = st.wave ^ st.ctrl[CTRL_INV];
	assign TIMER_IRQ_OUT          = BUS_MODE ? irq_bus : ovf_flag;
	assign WAKE_OUT               = st.wake;
	assign TIMER_RESET_PIN_ENABLE = RST_PIN_ENA;
	assign RUNNING_COUNT          = st.count;

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_st = st;

		// Synchronise pin clock and capture trigger
		next_st.tclk_sync1 = TIMER_CLOCK_IN;
		next_st.tclk_sync2 = st.tclk_sync1;
		next_st.tclk_prev  = st.tclk_sync2;
		next_st.cap_sync1  = CAPTURE_TRIGGER_IN;
		next_st.cap_sync2  = st.cap_sync1;
		next_st.cap_prev   = st.cap_sync2;

		// Prescaler counts source ticks
		if (st.ctrl[CTRL_RUN] && tick) begin
			if (st.prescale >= pre_limit(pre_sel)) begin
				next_st.prescale = 8'h00;
			end else begin
				next_st.prescale = st.prescale + 8'h01;
			end
		end

		// Counter stepping per mode
		if (step) begin
			case (mode)
				MODE_WDOG: begin
					// Free run, wraps at the period value
					next_st.count = at_top ? START_VALUE
						: st.count + 16'h0001;
				end
				MODE_CTC: begin
					// Reload after the compare match
					next_st.count = match ? START_VALUE
						: st.count + 16'h0001;
				end
				MODE_FPWM: begin
					// Single slope, buffers take effect at wrap
					if (at_top) begin
						next_st.count = START_VALUE;
						next_st.top   = st.top_buf;
						next_st.cmp   = st.cmp_buf;
					end else begin
						next_st.count = st.count + 16'h0001;
					end
				end
				MODE_PFCPWM: begin
					// Dual slope, buffers taken at the bottom
					if (st.dir == DIR_UP) begin
						if (at_top) begin
							next_st.dir   = DIR_DOWN;
							next_st.count = st.count - 16'h0001;
						end else begin
							next_st.count = st.count + 16'h0001;
						end
					end else begin
						if (at_zero) begin
							next_st.dir   = DIR_UP;
							next_st.top   = st.top_buf;
							next_st.cmp   = st.cmp_buf;
							next_st.count = st.count + 16'h0001;
						end else begin
							next_st.count = st.count - 16'h0001;
						end
					end
				end
				default: begin
					next_st.count = START_VALUE;
				end
			endcase
		end

		// Waveform generation per mode
		if (step) begin
			case (mode)
				MODE_FPWM: begin
					// Set at wrap, clear on match
					if (at_top) begin
						next_st.wave = 1'b1;
					end else if (match) begin
						next_st.wave = 1'b0;
					end
				end
				MODE_PFCPWM: begin
					// Clear on match rising, set on match falling
					if (match) begin
						next_st.wave = (st.dir == DIR_DOWN);
					end
				end
				default: begin
					// Toggle on compare match
					if (match) begin
						next_st.wave = !st.wave;
					end
				end
			endcase
		end

		// Capture stamps the count
		if (cap_ev) begin
			next_st.capture = st.count;
		end

		// Wake pulse on any unmasked event
		next_st.wake = |(events & st.mask);

		// Register writes over APB
		if (wr) begin
			case (PADDR)
				OFS_CTRL: begin
					next_st.ctrl = PWDATA[8:0];
				end
				OFS_TOP: begin
					next_st.top_buf = PWDATA[15:0];
					if (!pwm_mode) begin
						next_st.top = PWDATA[15:0];
					end
				end
				OFS_CMP: begin
					next_st.cmp_buf = PWDATA[15:0];
					if (!pwm_mode) begin
						next_st.cmp = PWDATA[15:0];
					end
				end
				OFS_COUNT: begin
					next_st.count = PWDATA[15:0];
				end
				OFS_STATUS: begin
					next_st.status = st.status & ~PWDATA[2:0];
				end
				OFS_MASK: begin
					next_st.mask = PWDATA[2:0];
				end
				OFS_IRQ_EN: begin
					next_st.irq_en = PWDATA[2:0];
				end
				default: begin
					next_st.status = st.status;
				end
			endcase
		end

		// Events set status; set beats a clear in the same cycle
		next_st.status = next_st.status | events;

		// Stand-alone: overflow flag clears at the next counter step without overflow
		if (!BUS_MODE && step && !ovf_ev) begin
			next_st.status[ST_OVF] = 1'b0;
		end

		// Read data captured in the setup phase, shown for the access only
		next_st.rdata = 32'h0000_0000;
		if (PSEL && !PENABLE && !PWRITE && BUS_MODE) begin
			case (PADDR)
				OFS_CTRL:    next_st.rdata = {23'h000000, st.ctrl};
				OFS_TOP:     next_st.rdata = {16'h0000, st.top_buf};
				OFS_CMP:     next_st.rdata = {16'h0000, st.cmp_buf};
				OFS_COUNT:   next_st.rdata = {16'h0000, st.count};
				OFS_CAPTURE: next_st.rdata = {16'h0000, st.capture};
				OFS_STATUS:  next_st.rdata = {29'h00000000, st.status};
				OFS_MASK:    next_st.rdata = {29'h00000000, st.mask};
				OFS_IRQ_EN:  next_st.rdata = {29'h00000000, st.irq_en};
				default:     next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// State register: bus reset or enabled pin reset loads the reset values
	always_ff @(posedge CLK) begin
		if (!RESETN || (RST_PIN_ENA && !TIMER_RESET_LOW)) begin
			st          <= '0;
			st.ctrl     <= CTRL_RESET;
			st.top      <= TOP_RESET;
			st.cmp      <= CMP_RESET;
			st.top_buf  <= TOP_RESET;
			st.cmp_buf  <= CMP_RESET;
			st.mask     <= IRQ_RESET;
			st.irq_en   <= IRQ_RESET;
			st.dir      <= DIR_UP;
		end else if (CE) begin
			st <= next_st;
			// Stand-alone forces the preloaded control word
			if (!BUS_MODE) begin
				st.ctrl <= CTRL_PRELOAD;
			end
		end
	end

endmodule

/* dv/tc_core_sva.sv */
// Port checker for the timer/counter block.
// Assumes one clock CLK and sync active-low RESETN.
`timescale 1ns/10ps
module tc_core_chk (
	// Clock and control
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        CE,
	input wire logic        BUS_MODE,
	// Register bus
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// Timer pins
	input wire logic        COMPARE_WAVE_OUT,
	input wire logic        TIMER_IRQ_OUT,
	input wire logic        WAKE_OUT,
	input wire logic        TIMER_RESET_PIN_ENABLE,
	input wire logic [15:0] RUNNING_COUNT
);
	default clocking cb @(posedge CLK); endclocking
	// ==========================================================
	// Pin, bus and reset relations
	pin_en_a: assert property (TIMER_RESET_PIN_ENABLE)
		else $error("reset pin enable dropped");
	ready_a: assert property (disable iff (!RESETN)
		PSEL && PENABLE |-> PREADY) else $error("access not ready");
	slverr_a: assert property (disable iff (!RESETN)
		PSEL && PENABLE && PADDR > 8'h1C |-> PSLVERR)
		else $error("unmapped access without error");
	unmap_rd_a: assert property (disable iff (!RESETN)
		PSEL && PENABLE && !PWRITE && PADDR > 8'h1C |-> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	idle_rd_a: assert property (disable iff (!RESETN)
		!PSEL |-> PRDATA == 32'h0) else $error("read data outside access");
	alone_rd_a: assert property (disable iff (!RESETN)
		!BUS_MODE && PSEL && PENABLE |-> PRDATA == 32'h0)
		else $error("stand-alone read not zero");
	reset_out_a: assert property (!RESETN |=> RUNNING_COUNT == 16'h0
		&& !TIMER_IRQ_OUT && !WAKE_OUT && !COMPARE_WAVE_OUT)
		else $error("outputs not cleared by reset");
	stall_a: assert property (disable iff (!RESETN)
		!CE |=> $stable(RUNNING_COUNT)) else $error("count moved while held");
endmodule

bind tc_core tc_core_chk u_chk (.CLK(CLK), .RESETN(RESETN), .CE(CE),
	.BUS_MODE(BUS_MODE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.COMPARE_WAVE_OUT(COMPARE_WAVE_OUT), .TIMER_IRQ_OUT(TIMER_IRQ_OUT),
	.WAKE_OUT(WAKE_OUT), .TIMER_RESET_PIN_ENABLE(TIMER_RESET_PIN_ENABLE),
	.RUNNING_COUNT(RUNNING_COUNT));

/* dv/tc_pin_model.sv */
// Far-side pin logic: external count clock and capture trigger.
// Assumes the bench pulses fire for one cycle to request a trigger.
`timescale 1ns/10ps
module tc_pin_model (
	// Clock
	input wire logic CLK,
	// Requests from the bench
	input wire logic clk_on,
	input wire logic fire,
	// Pins toward the timer
	output logic     tclk,
	output logic     trig
);
	logic [2:0] div = 3'h0;  // Free divider, period of eight
	logic [2:0] hold = 3'h0; // Trigger length left
	initial tclk = 1'b0;
	initial trig = 1'b0;
	// Clock stands low while off; trigger is four cycles high
	always @(posedge CLK) begin
		div <= div + 3'h1;
		tclk <= clk_on & div[2];
		if (fire) begin
			hold <= 3'h4;
		end else if (hold != 3'h0) begin
			hold <= hold - 3'h1;
		end
		trig <= (hold != 3'h0);
	end
endmodule

/* dv/test_bidir_timer_counter_pwm.sv */
// Self-checking bench for the timer/counter block.
// Assumes tc_pkg offsets and a zero-wait APB slave.
`timescale 1ns/10ps
module test_bidir_timer_counter_pwm;
	import tc_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d, e; logic err;} row_t;
	logic        clk, resetn = 1'b0, ce = 1'b1, trst_low = 1'b1;
	logic        bus_mode = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, wave, irq, wake, pin_en, tclk, trig, er;
	logic        clk_on = 1'b0, fire = 1'b0, down;
	logic [15:0] cnt, c0, mx;
	int          bad_count = 0, check_count = 0, ones, ones2;
	row_t        rows[10];
	// ==========================================================
	// Clock, design and pin model
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	tc_core u_dut (.CLK(clk), .CE(ce), .RESETN(resetn),
		.TIMER_RESET_LOW(trst_low), .BUS_MODE(bus_mode), .TIMER_CLOCK_IN(tclk),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CAPTURE_TRIGGER_IN(trig), .COMPARE_WAVE_OUT(wave),
		.TIMER_IRQ_OUT(irq), .WAKE_OUT(wake),
		.TIMER_RESET_PIN_ENABLE(pin_en), .RUNNING_COUNT(cnt));
	tc_pin_model u_pin (.CLK(clk), .clk_on(clk_on), .fire(fire),
		.tclk(tclk), .trig(trig));
	// ==========================================================
	// Shared tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
		rd = prdata; er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (pready !== 1'b1) begin bad_count++; test_done(); end
	endtask
	task automatic waitc(input logic [15:0] v);
		int n;
		n = 0;
		while (cnt !== v && n < 200) begin @(negedge clk); n++; end
		if (n >= 200) begin bad_count++; test_done(); end
	endtask
	task automatic pulse();
		@(posedge clk) fire <= 1'b1;
		@(posedge clk) fire <= 1'b0;
		repeat (10) @(negedge clk);
	endtask
	// Wave high time, peak count and any single down step
	task automatic meas(input int n);
		ones = 0; mx = 16'h0; down = 1'b0; c0 = cnt;
		repeat (n) begin
			@(negedge clk);
			ones += int'(wave);
			if (cnt > mx) mx = cnt;
			if (cnt + 16'h1 == c0) down = 1'b1;
			c0 = cnt;
		end
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		rows[0] = '{1'b0, OFS_CTRL, 32'h0, 32'h0, 1'b0};
		rows[1] = '{1'b0, OFS_TOP, 32'h0, 32'hFFFF, 1'b0};
		rows[2] = '{1'b0, OFS_CMP, 32'h0, 32'h8000, 1'b0};
		rows[3] = '{1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0};
		rows[4] = '{1'b1, OFS_TOP, 32'hABCD1234, 32'h1234, 1'b0};
		rows[5] = '{1'b1, OFS_CMP, 32'h3, 32'h3, 1'b0};
		rows[6] = '{1'b1, OFS_MASK, 32'hFF, 32'h7, 1'b0};
		rows[7] = '{1'b1, OFS_IRQ_EN, 32'h5, 32'h5, 1'b0};
		rows[8] = '{1'b1, OFS_CAPTURE, 32'hFFFF, 32'h0, 1'b0};
		rows[9] = '{1'b1, 8'h20, 32'hFF, 32'h0, 1'b1};
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].e);
			chk({31'h0, er}, {31'h0, rows[i].err});
		end
		$display("registers done");
		// Clear on match, compare event, wake and interrupt gating
		apb(1'b1, OFS_CTRL, 32'h003);
		waitc(16'h3);
		@(negedge clk) chk(cnt, 32'h0);
		meas(8);
		ones = 0;
		repeat (8) begin @(negedge clk); ones += int'(wake); end
		chk(ones, 2);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h2);
		@(negedge clk) chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFS_IRQ_EN, 32'h7);
		@(negedge clk) chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_STATUS, 32'h7);
		@(negedge clk) chk({31'h0, irq}, 32'h0);
		$display("ctc done");
		// Capture stamps the frozen count, not in fast PWM mode
		apb(1'b1, OFS_CTRL, 32'h080);
		apb(1'b1, OFS_COUNT, 32'h123);
		pulse();
		apb(1'b0, OFS_CAPTURE, 32'h0);
		chk(rd, 32'h123);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h4);
		apb(1'b1, OFS_STATUS, 32'h7);
		apb(1'b1, OFS_CTRL, 32'h084);
		apb(1'b1, OFS_COUNT, 32'h456);
		pulse();
		apb(1'b0, OFS_CAPTURE, 32'h0);
		chk(rd, 32'h123);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		$display("capture done");
		// Prescale by four, then pin clock of period eight
		apb(1'b1, OFS_CTRL, 32'h021);
		@(negedge clk) c0 = cnt;
		repeat (40) @(negedge clk);
		chk(cnt - c0, 32'hA);
		@(posedge clk) clk_on <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h009);
		repeat (20) @(negedge clk);
		c0 = cnt;
		repeat (80) @(negedge clk);
		chk(cnt - c0, 32'hA);
		@(posedge clk) clk_on <= 1'b0;
		// Fast PWM, inverted output, dual-slope PWM
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_COUNT, 32'h0);
		apb(1'b1, OFS_TOP, 32'h9);
		apb(1'b1, OFS_CMP, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h005);
		repeat (20) @(negedge clk);
		meas(100);
		ones2 = ones;
		chk(mx, 32'h9);
		chk({31'h0, ones2 inside {30, 40, 60, 70}}, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h105);
		repeat (20) @(negedge clk);
		meas(100);
		chk(ones, 100 - ones2);
		apb(1'b1, OFS_CTRL, 32'h007);
		repeat (20) @(negedge clk);
		meas(40);
		chk(mx, 32'h9);
		chk({31'h0, down}, 32'h1);
		$display("pwm done");
		// Stand-alone: preload runs, bus reads zero, overflow on irq
		@(posedge clk) bus_mode <= 1'b0;
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(negedge clk);
		c0 = cnt;
		repeat (10) @(negedge clk);
		chk(cnt - c0, 32'hA);
		apb(1'b1, OFS_TOP, 32'h5);
		apb(1'b0, OFS_TOP, 32'h0);
		chk(rd, 32'h0);
		@(posedge clk) ce <= 1'b0;
		@(negedge clk) c0 = cnt;
		repeat (5) @(negedge clk);
		chk(cnt, c0);
		@(posedge clk) ce <= 1'b1;
		for (int i = 0; i < 70000 && irq !== 1'b1; i++) @(negedge clk);
		chk({31'h0, irq}, 32'h1);
		@(posedge clk) trst_low <= 1'b0;
		@(posedge clk) trst_low <= 1'b1;
		@(negedge clk) chk(cnt, 32'h0);
		chk({31'h0, pin_en}, 32'h1);
		$display("stand-alone done");
		test_done();
	end
endmodule
